// >>> logic/iram_pkg.sv
// Package: shared constants and types for the internal RAM access block
package iram_pkg;
    localparam logic [7:0] STACK_RESET       = 8'h07;  // Stack pointer value after reset
    localparam logic [7:0] STACK_PTR_ADDR    = 8'h81;  // Special register address of the stack pointer
    localparam logic [7:0] BIT_AREA_BASE     = 8'h20;  // First byte of bit-addressable RAM
    localparam logic [7:0] SPECIAL_BASE      = 8'h80;  // Start of special register space
    localparam logic [7:0] ZERO_BYTE         = 8'h00;  // Read value of unassigned special addresses
    localparam int         BANK_SHIFT        = 3;      // Bank number times eight

    // Access command issued by the core
    typedef enum logic [2:0] {
        OP_IDLE     = 3'b000,
        OP_DIRECT   = 3'b001,
        OP_INDIRECT = 3'b010,
        OP_WORKREG  = 3'b011,
        OP_BIT      = 3'b100,
        OP_PUSH     = 3'b101,
        OP_POP      = 3'b110
    } mem_op_t;

    // Bit operation kind
    typedef enum logic [1:0] {
        BIT_TEST  = 2'b00,
        BIT_SET   = 2'b01,
        BIT_CLEAR = 2'b10
    } bit_op_t;

    // One request from the core
    typedef struct packed {
        mem_op_t    op;     // Access kind
        logic       write;  // Byte write when set (direct, indirect, working register)
        bit_op_t    bop;    // Bit operation
        logic [7:0] addr;   // Byte, bit or working register address
        logic [7:0] wdata;  // Write or push data
    } mem_req_t;

    // One answer to the core
    typedef struct packed {
        logic       valid;  // One-cycle answer marker
        logic [7:0] rdata;  // Byte read or popped
        logic       bit_val; // Tested bit value
    } mem_rsp_t;
endpackage

// >>> logic/iram_array.sv
// Storage: 256-byte internal RAM array with one synchronous write port and one async read
`timescale 1ns/1ps
`default_nettype none
module iram_array (
    input  wire logic       clk,    // Core clock
    input  wire logic       we,     // Write strobe
    input  wire logic [7:0] waddr,  // Write address
    input  wire logic [7:0] wdata,  // Write data
    input  wire logic [7:0] raddr,  // Read address
    output logic      [7:0] rdata   // Read data, combinational
);
    logic [7:0] mem [0:255];  // Contents are random after power-up, as on the real part

    ////////////////////////////////////////////////////////////////////////////
    // Write port; no reset on purpose, RAM contents are undefined at start
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port
    assign rdata = mem[raddr];
endmodule
`default_nettype wire

// >>> logic/iram_access.sv
// Top: internal RAM decoding, stack, register banks and bit access
`timescale 1ns/1ps
`default_nettype none
module iram_access
    import iram_pkg::*;
(
    input  wire logic                CLK,        // Core clock, 100 MHz
    input  wire logic                NRST,       // Asynchronous reset, active low
    input  wire iram_pkg::mem_req_t  REQ,        // Request from the core, taken each cycle
    input  wire logic [1:0]          BANK_SEL,   // Bank select field from the status word
    input  wire logic [7:0]          SFR_RDATA,  // Read data from the outer special register file
    input  wire logic                SFR_HIT,    // Outer file has a register at the special address of the current request
    output iram_pkg::mem_rsp_t       RSP,        // Registered answer
    output logic [7:0]               SFR_ADDR,   // Special register address for write
    output logic [7:0]               SFR_WDATA,  // Special register write data
    output logic                     SFR_WE,     // Special register write strobe, one cycle
    output logic [7:0]               STACK_TOP   // Current stack pointer
);
    import iram_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address helpers

    // Working register address in the selected bank
    function automatic logic [7:0] reg_addr(input logic [1:0] bank, input logic [2:0] idx);
        reg_addr = {3'h0, bank, idx};
    endfunction

    // Byte holding a bit address: RAM byte or special register
    function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
        if (baddr[7]) begin
            bit_byte = {baddr[7:3], 3'h0};
        end else begin
            bit_byte = BIT_AREA_BASE + {4'h0, baddr[6:3]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] stack_top_pointer;       // Stack pointer register
    logic [7:0] next_stack_top_pointer;  // Its next value
    mem_rsp_t   rsp;                     // Answer register
    mem_rsp_t   next_rsp;                // Its next value
    logic [7:0] sfr_addr;                // Registered special address
    logic [7:0] next_sfr_addr;
    logic [7:0] sfr_wdata;               // Registered special write data
    logic [7:0] next_sfr_wdata;
    logic       sfr_we;                  // Registered special write strobe
    logic       next_sfr_we;
    logic       ram_we;                  // RAM write strobe
    logic [7:0] ram_addr;                // RAM address for read and write
    logic [7:0] ram_wdata;               // RAM write data
    logic [7:0] ram_rdata;               // RAM read data
    logic [7:0] byte_addr;               // Decoded byte address
    logic       to_special;              // Access targets special space
    logic [7:0] cur_byte;                // Current value of the addressed byte
    logic [7:0] mod_byte;                // Byte with one bit changed
    logic       sp_hit;                  // Special address is the stack pointer

    ////////////////////////////////////////////////////////////////////////////
    // RAM instance
    iram_array u_ram (
        .clk   (CLK),
        .we    (ram_we),
        .waddr (ram_addr),
        .wdata (ram_wdata),
        .raddr (ram_addr),
        .rdata (ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and read-modify-write of one byte
    always_comb begin
        byte_addr  = REQ.addr;
        to_special = 1'b0;
        if (REQ.op == OP_DIRECT) begin
            to_special = REQ.addr[7];
        end else if (REQ.op == OP_WORKREG) begin
            byte_addr = reg_addr(BANK_SEL, REQ.addr[2:0]);
        end else if (REQ.op == OP_BIT) begin
            byte_addr  = bit_byte(REQ.addr);
            to_special = REQ.addr[7];
        end else if (REQ.op == OP_PUSH) begin
            byte_addr = stack_top_pointer + 8'h01;
        end else if (REQ.op == OP_POP) begin
            byte_addr = stack_top_pointer;
        end
        // Indirect keeps the full address: besides push and pop, the only path to upper RAM
        sp_hit = to_special && (byte_addr == STACK_PTR_ADDR);
        if (!to_special) begin
            cur_byte = ram_rdata;
        end else if (sp_hit) begin
            cur_byte = stack_top_pointer;
        end else if (sfr_we && (sfr_addr == byte_addr)) begin
            // Outer file lands our write one edge late; forward it so back-to-back access sees it
            cur_byte = sfr_wdata;
        end else if (SFR_HIT) begin
            cur_byte = SFR_RDATA;
        end else begin
            cur_byte = ZERO_BYTE;
        end
        mod_byte = cur_byte;
        mod_byte[REQ.addr[2:0]] = (REQ.bop == BIT_SET);
        ram_addr = byte_addr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: stack, writes and answer
    always_comb begin
        next_stack_top_pointer = stack_top_pointer;
        next_rsp               = '0;
        next_sfr_addr          = sfr_addr;
        next_sfr_wdata         = sfr_wdata;
        next_sfr_we            = 1'b0;
        ram_we                 = 1'b0;
        ram_wdata              = REQ.wdata;
        case (REQ.op)
            OP_DIRECT, OP_INDIRECT, OP_WORKREG: begin
                next_rsp.valid = 1'b1;
                next_rsp.rdata = cur_byte;
                if (REQ.write) begin
                    if (!to_special) begin
                        ram_we = 1'b1;
                    end else if (sp_hit) begin
                        next_stack_top_pointer = REQ.wdata;
                    end else if (SFR_HIT) begin
                        next_sfr_we    = 1'b1;
                        next_sfr_addr  = byte_addr;
                        next_sfr_wdata = REQ.wdata;
                    end
                    // Unassigned special write is simply dropped
                end
            end
            OP_BIT: begin
                next_rsp.valid   = 1'b1;
                next_rsp.rdata   = cur_byte;
                next_rsp.bit_val = cur_byte[REQ.addr[2:0]];
                if (REQ.bop != BIT_TEST) begin
                    ram_wdata = mod_byte;
                    if (!to_special) begin
                        ram_we = 1'b1;
                    end else if (sp_hit) begin
                        next_stack_top_pointer = mod_byte;
                    end else if (SFR_HIT) begin
                        next_sfr_we    = 1'b1;
                        next_sfr_addr  = byte_addr;
                        next_sfr_wdata = mod_byte;
                    end
                end
            end
            OP_PUSH: begin
                // Return addresses from calls and interrupts also come in here
                ram_we                 = 1'b1;
                next_stack_top_pointer = byte_addr;
                next_rsp.valid         = 1'b1;
            end
            OP_POP: begin
                next_rsp.valid         = 1'b1;
                next_rsp.rdata         = ram_rdata;
                next_stack_top_pointer = stack_top_pointer - 8'h01;
            end
            default: begin
                next_rsp.valid = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; no check of stack overrun into banks or bit area
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            stack_top_pointer <= STACK_RESET;
            rsp               <= '0;
            sfr_addr          <= ZERO_BYTE;
            sfr_wdata         <= ZERO_BYTE;
            sfr_we            <= 1'b0;
        end else begin
            stack_top_pointer <= next_stack_top_pointer;
            rsp               <= next_rsp;
            sfr_addr          <= next_sfr_addr;
            sfr_wdata         <= next_sfr_wdata;
            sfr_we            <= next_sfr_we;
        end
    end

    // Outputs straight from flip-flops
    assign RSP       = rsp;
    assign SFR_ADDR  = sfr_addr;
    assign SFR_WDATA = sfr_wdata;
    assign SFR_WE    = sfr_we;
    assign STACK_TOP = stack_top_pointer;
endmodule
`default_nettype wire

// >>> sim/iram_access_sva.sv
// Checker: port-level assertions for the internal RAM access block
`timescale 1ns/1ps
`default_nettype none
module iram_access_sva
    import iram_pkg::*;
(
    input wire logic       CLK,
    input wire logic       NRST,
    input wire mem_req_t   REQ,
    input wire logic [1:0] BANK_SEL,
    input wire logic [7:0] SFR_RDATA,
    input wire logic       SFR_HIT,
    input wire mem_rsp_t   RSP,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic       SFR_WE,
    input wire logic [7:0] STACK_TOP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////
    logic dsp;  // Direct access to special space, pointer excluded
    logic spw;  // Direct write to the pointer itself
    assign dsp = REQ.op == OP_DIRECT && REQ.addr[7] && REQ.addr != STACK_PTR_ADDR;
    assign spw = REQ.op == OP_DIRECT && REQ.write && REQ.addr == STACK_PTR_ADDR;
    push_step_a: assert property (REQ.op == OP_PUSH |=> STACK_TOP == $past(STACK_TOP) + 8'h01)
        else $error("push step wrong");
    pop_step_a: assert property (REQ.op == OP_POP |=> STACK_TOP == $past(STACK_TOP) - 8'h01)
        else $error("pop step wrong");
    sp_hold_a: assert property (!(REQ.op inside {OP_PUSH, OP_POP}) && !spw |=> $stable(STACK_TOP))
        else $error("pointer moved");
    ram_only_a: assert property ((REQ.op inside {OP_INDIRECT, OP_WORKREG, OP_PUSH, OP_POP})
        || (REQ.op inside {OP_BIT, OP_DIRECT} && !REQ.addr[7]) |=> !SFR_WE)
        else $error("RAM access hit special space");
    sfr_write_a: assert property (dsp && REQ.write && SFR_HIT |=> SFR_WE && SFR_ADDR == $past(REQ.addr)
        && SFR_WDATA == $past(REQ.wdata)) else $error("special write lost");
    unassigned_rd_a: assert property (dsp && !REQ.write && !SFR_HIT |=> RSP.rdata == ZERO_BYTE)
        else $error("unassigned read not zero");
    drop_write_a: assert property (dsp && REQ.write && !SFR_HIT |=> !SFR_WE)
        else $error("unassigned write kept");
    bit_set_sfr_a: assert property (REQ.op == OP_BIT && REQ.bop == BIT_SET && REQ.addr[7] && SFR_HIT
        |=> SFR_WE && SFR_ADDR == {$past(REQ.addr[7:3]), 3'b000}
        && SFR_WDATA == ((($past(SFR_WE) && $past(SFR_ADDR) == {$past(REQ.addr[7:3]), 3'b000})
        ? $past(SFR_WDATA) : $past(SFR_RDATA)) | (8'h01 << $past(REQ.addr[2:0])))) else $error("bit set wrong");
    push_c: cover property (REQ.op == OP_PUSH ##1 REQ.op == OP_PUSH);
    bit_sfr_c: cover property (REQ.op == OP_BIT && REQ.addr[7] && SFR_HIT);
    unassigned_c: cover property (dsp && !SFR_HIT);
endmodule
bind iram_access iram_access_sva iram_access_sva_inst (.CLK(CLK), .NRST(NRST), .REQ(REQ), .BANK_SEL(BANK_SEL),
    .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .RSP(RSP), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WE(SFR_WE), .STACK_TOP(STACK_TOP));
`default_nettype wire

// >>> sim/sfr_model.sv
// Partner: outer special register file with registers at 80h and 88h
`timescale 1ns/1ps
`default_nettype none
module sfr_model
    import iram_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire mem_req_t   req,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_we,
    output logic      [7:0] rdata,
    output logic            hit
);
    logic [7:0] port_reg;  // Register at 80h
    logic [7:0] ctl_reg;   // Register at 88h
    logic [7:0] sel;       // Decoded special address
    // Bit operations select the aligned register
    assign sel = (req.op == OP_BIT) ? {req.addr[7:3], 3'b000} : req.addr;
    assign hit = (sel == 8'h80) || (sel == 8'h88);
    // Unselected reads show junk, so a leak of it is seen
    assign rdata = (sel == 8'h80) ? port_reg : (sel == 8'h88) ? ctl_reg : 8'hC3;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_reg <= 8'h00;
            ctl_reg <= 8'h00;
        end else if (sfr_we && sfr_addr == 8'h80) begin
            port_reg <= sfr_wdata;
        end else if (sfr_we && sfr_addr == 8'h88) begin
            ctl_reg <= sfr_wdata;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Testbench: directed access sequences for the internal RAM block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import iram_pkg::*;
    logic       clk, nrst, s_hit, s_we;
    logic [1:0] bank_sel;
    logic [7:0] s_rdata, s_addr, s_wdata, sp;
    mem_req_t   req;
    mem_rsp_t   rsp, got;
    int         mismatches, tests_run;
    iram_access iram_access_inst (.CLK(clk), .NRST(nrst), .REQ(req), .BANK_SEL(bank_sel), .SFR_RDATA(s_rdata),
        .SFR_HIT(s_hit), .RSP(rsp), .SFR_ADDR(s_addr), .SFR_WDATA(s_wdata), .SFR_WE(s_we), .STACK_TOP(sp));
    sfr_model sfr_model_inst (.clk(clk), .nrst(nrst), .req(req), .sfr_addr(s_addr), .sfr_wdata(s_wdata),
        .sfr_we(s_we), .rdata(s_rdata), .hit(s_hit));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Request at a falling edge; answer read one falling edge later
    task automatic acc(input mem_op_t op, input logic w, input bit_op_t b, input logic [7:0] a, d);
        req = '{op, w, b, a, d};
        @(negedge clk);
        got = rsp;
        chk({7'h00, got.valid}, 8'h01);
    endtask
    task automatic rd(input mem_op_t op, input logic [7:0] a, e);
        acc(op, 1'b0, BIT_TEST, a, 8'h00);
        chk(got.rdata, e);
    endtask
    task automatic wr(input mem_op_t op, input logic [7:0] a, d);
        acc(op, 1'b1, BIT_TEST, a, d);
    endtask
    // Bit answer carries the value from before the operation
    task automatic bt(input bit_op_t b, input logic [7:0] a, input logic e);
        acc(OP_BIT, 1'b0, b, a, 8'h00);
        chk({7'h00, got.bit_val}, {7'h00, e});
    endtask
    task automatic rst();
        req = '{OP_IDLE, 1'b0, BIT_TEST, 8'h00, 8'h00};
        nrst = 1'b0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        bank_sel = 2'b00;
        rst();
        chk(sp, STACK_RESET);
        wr(OP_PUSH, 8'h00, 8'h11);
        chk(sp, 8'h08);
        wr(OP_PUSH, 8'h00, 8'h22);
        rd(OP_DIRECT, 8'h08, 8'h11);
        bank_sel = 2'b01;
        rd(OP_WORKREG, 8'h01, 8'h22);
        rd(OP_POP, 8'h00, 8'h22);
        chk(sp, 8'h08);
        $display("stack test done");
        for (int b = 0; b < 4; b++) begin
            bank_sel = b[1:0];
            wr(OP_WORKREG, 8'h04, 8'h40 + b[7:0]);
        end
        for (int b = 0; b < 4; b++) rd(OP_DIRECT, 8'h04 + 8 * b[7:0], 8'h40 + b[7:0]);
        $display("bank test done");
        wr(OP_DIRECT, STACK_PTR_ADDR, 8'h30);
        rd(OP_DIRECT, STACK_PTR_ADDR, 8'h30);
        wr(OP_DIRECT, 8'h20, 8'hFF);
        for (int n = 0; n < 8; n++) bt(BIT_TEST, n[7:0], 1'b1);
        wr(OP_DIRECT, 8'h24, 8'h00);
        bt(BIT_SET, 8'h24, 1'b0);
        rd(OP_DIRECT, 8'h24, 8'h10);
        bt(BIT_CLEAR, 8'h00, 1'b1);
        rd(OP_DIRECT, 8'h20, 8'hFE);
        wr(OP_DIRECT, 8'h2F, 8'h01);
        bt(BIT_SET, 8'h7F, 1'b0);
        rd(OP_DIRECT, 8'h2F, 8'h81);
        $display("bit test done");
        bt(BIT_SET, 8'h83, 1'b0);
        bt(BIT_SET, 8'h80, 1'b0);
        rd(OP_DIRECT, 8'h80, 8'h09);
        bt(BIT_CLEAR, 8'h83, 1'b1);
        wr(OP_DIRECT, 8'h88, 8'hAA);
        bt(BIT_TEST, 8'h8F, 1'b1);
        wr(OP_DIRECT, 8'h90, 8'h55);
        rd(OP_DIRECT, 8'h90, 8'h00);
        wr(OP_INDIRECT, 8'h90, 8'h66);
        rd(OP_INDIRECT, 8'h90, 8'h66);
        wr(OP_INDIRECT, 8'h80, 8'h77);
        rd(OP_DIRECT, 8'h80, 8'h01);
        wr(OP_DIRECT, 8'h50, 8'h12);
        rd(OP_INDIRECT, 8'h50, 8'h12);
        $display("special test done");
        wr(OP_DIRECT, STACK_PTR_ADDR, 8'hFF);
        wr(OP_PUSH, 8'h00, 8'h33);
        chk(sp, 8'h00);
        rd(OP_POP, 8'h00, 8'h33);
        chk(sp, 8'hFF);
        rst();
        chk(sp, STACK_RESET);
        $display("wrap test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
